// ---- verification/drive_pair_model.sv ----
// Behavioural pair of drives behind the interface
`timescale 1ns/100ps
`default_nettype none
module drive_pair_model
    import ide_port_pkg::*;
(
    // Clock and strobes
    input  wire logic              clk_sys_i,
    input  wire logic              pri_rd_n_i,
    input  wire logic              sec_rd_n_i,
    input  wire logic              pri_wr_n_i,
    input  wire logic              sec_wr_n_i,
    // Address and host data
    input  wire logic [ADDR_W-1:0] index_i,
    input  wire logic [DATA_W-1:0] bus_i,
    // Drive data and last captured write
    output logic [DATA_W-1:0]      data_o,
    output logic [DATA_W-1:0]      wr_word_o,
    output logic [ADDR_W:0]        wr_tag_o
);
    // ====================
    // Read answers
    logic [DATA_W-1:0] last_ff;
    // Word per port and index while read strobe low, else churn
    always_comb
    begin
        if (!pri_rd_n_i || !sec_rd_n_i)
            data_o = 16'h5a00 | {12'h000, !sec_rd_n_i, index_i};
        else
            data_o = ~last_ff;
    end
    // Remember the last word driven on data_o
    always_ff @(posedge clk_sys_i) last_ff <= data_o;
    // ====================
    // Which port strobed last; only one port strobes at a time
    logic sec_last;
    always @(negedge pri_wr_n_i or negedge sec_wr_n_i)
        sec_last <= !sec_wr_n_i;
    // Write capture on rising strobes of either drive
    always @(posedge pri_wr_n_i or posedge sec_wr_n_i)
    begin
        wr_word_o <= bus_i;
        wr_tag_o  <= {sec_last, index_i};
    end
endmodule // drive_pair_model
`default_nettype wire

// ---- verification/ide_dual_port_interface_checker.sv ----
// Concurrent checks on the drive interface ports
`timescale 1ns/100ps
`default_nettype none
module ide_dual_port_interface_checker
    import ide_port_pkg::*;
(
    // Clock, reset, host side
    input wire logic              clk_sys_i,
    input wire logic              rst_i,
    input wire logic              req_ready_o,
    input wire logic              req_aux_i,
    input wire logic              req_dma_i,
    input wire logic              pri_dma_pending_o,
    input wire logic              sec_dma_pending_o,
    // Drive side
    input wire logic              cmd_block_select_n_o,
    input wire logic              aux_block_select_n_o,
    input wire logic              aux_block_select_n_oe_o,
    input wire logic              pri_write_strobe_n_o,
    input wire logic              pri_read_strobe_n_o,
    input wire logic              sec_write_strobe_n_o,
    input wire logic              sec_read_strobe_n_o,
    input wire logic [DATA_W-1:0] drive_word_bus_o,
    input wire logic              drive_word_bus_oe_o,
    input wire logic              pri_dma_ack_n_o,
    input wire logic              sec_dma_ack_n_o,
    input wire logic              drive_channel_ready_i
);
    // ====================
    // Strobe summaries
    logic wr_low;
    logic rd_low;
    assign wr_low = !pri_write_strobe_n_o || !sec_write_strobe_n_o;
    assign rd_low = !pri_read_strobe_n_o || !sec_read_strobe_n_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // ====================
    // Properties
    chk_strobe_excl: assert property (
        !(!pri_write_strobe_n_o && !pri_read_strobe_n_o) &&
        !(!sec_write_strobe_n_o && !sec_read_strobe_n_o))
        else $error("read and write strobe low together");
    chk_reset_idle: assert property (disable iff (1'h0) rst_i |=>
        pri_write_strobe_n_o && pri_read_strobe_n_o && sec_write_strobe_n_o
        && sec_read_strobe_n_o && !aux_block_select_n_oe_o)
        else $error("strobes or strap pin active in reset");
    chk_strobe_qual: assert property ((wr_low || rd_low) |->
        !cmd_block_select_n_o || !aux_block_select_n_o ||
        !pri_dma_ack_n_o || !sec_dma_ack_n_o)
        else $error("strobe without select");
    chk_cmd_select: assert property (req_ready_o && !req_aux_i &&
        !req_dma_i |-> !cmd_block_select_n_o && aux_block_select_n_o)
        else $error("command select wrong");
    chk_aux_select: assert property (req_ready_o && req_aux_i &&
        !req_dma_i |-> cmd_block_select_n_o && !aux_block_select_n_o)
        else $error("auxiliary select wrong");
    chk_ready_stretch: assert property (
        ((wr_low || rd_low) && !drive_channel_ready_i) [*2] |=>
        (wr_low || rd_low)) else $error("strobe ended while not ready");
    chk_pri_ack: assert property ($fell(pri_dma_ack_n_o) |->
        $past(pri_dma_pending_o)) else $error("primary ack unrequested");
    chk_sec_ack: assert property ($fell(sec_dma_ack_n_o) |->
        $past(sec_dma_pending_o)) else $error("secondary ack unrequested");
    chk_bus_dir: assert property ((wr_low || rd_low) |->
        drive_word_bus_oe_o == wr_low) else $error("data bus direction");
    chk_write_hold: assert property ($fell(wr_low) |->
        drive_word_bus_oe_o && $stable(drive_word_bus_o))
        else $error("write data not held at strobe rise");
    // Main scenarios
    cover property (rd_low && !drive_channel_ready_i);
    cover property ($fell(pri_dma_ack_n_o));
    cover property ($fell(wr_low));
endmodule // ide_dual_port_interface_checker
`default_nettype wire

// ---- verification/ide_dual_port_interface_tb_top.sv ----
// Self-checking bench for the dual-port drive interface
`timescale 1ns/100ps
`default_nettype none
module ide_dual_port_interface_tb_top
    import ide_port_pkg::*;
;
    // ====================
    // Signals named as the ports
    logic clk_sys_i = 1'h0;
    logic rst_i, req_valid_i, req_ready_o, req_write_i, req_sec_i, req_aux_i;
    logic req_dma_i, rd_valid_o, rd_ready_i, native_mode_o, pri_irq_o;
    logic sec_irq_o, pri_dma_pending_o, sec_dma_pending_o, strap;
    logic cmd_block_select_n_o, aux_block_select_n_i, aux_block_select_n_o;
    logic aux_block_select_n_oe_o, pri_write_strobe_n_o, pri_read_strobe_n_o;
    logic sec_write_strobe_n_o, sec_read_strobe_n_o, drive_word_bus_oe_o;
    logic pri_dma_request_i, pri_dma_ack_n_o, sec_dma_request_i;
    logic sec_dma_ack_n_o, drive_channel_ready_i, pri_drive_irq_i;
    logic sec_drive_irq_i;
    logic [ADDR_W-1:0] req_index_i, drive_reg_index_o;
    logic [ADDR_W:0] wr_tag;
    logic [DATA_W-1:0] req_wdata_i, rd_data_o, drive_word_bus_i;
    logic [DATA_W-1:0] drive_word_bus_o, model_data, wr_word;
    int err_count;
    int checks_done;
    // Clock, pin resolution, parts
    always #12.5 clk_sys_i = ~clk_sys_i;
    assign aux_block_select_n_i = aux_block_select_n_oe_o ?
                                  aux_block_select_n_o : strap;
    assign drive_word_bus_i = drive_word_bus_oe_o ? drive_word_bus_o
                                                  : model_data;
    ide_dual_port_interface dut_u (.*);
    drive_pair_model model_u (.clk_sys_i(clk_sys_i),
        .pri_rd_n_i(pri_read_strobe_n_o), .sec_rd_n_i(sec_read_strobe_n_o),
        .pri_wr_n_i(pri_write_strobe_n_o), .sec_wr_n_i(sec_write_strobe_n_o),
        .index_i(drive_reg_index_o), .bus_i(drive_word_bus_o),
        .data_o(model_data), .wr_word_o(wr_word), .wr_tag_o(wr_tag));
    // ====================
    // Shared tasks
    task automatic cmp(input string what, input logic [15:0] exp, got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic put(input logic w, s, a, d, input logic [2:0] i,
                       input logic [15:0] wd);
        {req_write_i, req_sec_i, req_aux_i, req_dma_i} = {w, s, a, d};
        req_index_i = i;
        req_wdata_i = wd;
        req_valid_i = 1'h1;
    endtask
    task automatic take(input int lim, input logic exp);
        int n;
        n = 0;
        do begin @(posedge clk_sys_i); n++; end
        while (req_ready_o !== 1'h1 && n < lim);
        cmp("taken", {15'h0, exp}, {15'h0, req_ready_o === 1'h1});
        #1;
        if (exp) req_valid_i = 1'h0;
    endtask
    task automatic get(input logic [15:0] exp, input int stall,
                       output int low);
        low = 0;
        for (int n = 0; n < 80; n++)
        begin
            @(posedge clk_sys_i);
            if (rd_valid_o === 1'h1) break;
            if (!pri_read_strobe_n_o || !sec_read_strobe_n_o) low++;
            if (n == stall) #1 drive_channel_ready_i = 1'h1;
        end
        cmp("rd_data", exp, rd_data_o);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ====================
    // Scenarios
    task automatic t_reset(input logic s);
        strap = s;
        rst_i = 1'h1;
        tick(8);
        rst_i = 1'h0;
        tick(4);
        cmp("native", {15'h0, s}, {15'h0, native_mode_o});
        cmp("strap_oe", 16'h1, {15'h0, aux_block_select_n_oe_o});
    endtask
    task automatic t_wr(input logic s, a, input logic [2:0] i,
                        input logic [15:0] d);
        put(1'h1, s, a, 1'h0, i, d);
        take(40, 1'h1);
        tick(14);
        cmp("wr_word", d, wr_word);
        cmp("wr_tag", {12'h0, s, i}, {12'h0, wr_tag});
    endtask
    task automatic t_rd(input logic s, a, input logic [2:0] i, input int st);
        int low;
        drive_channel_ready_i = (st == 0);
        put(1'h0, s, a, 1'h0, i, 16'h0);
        take(40, 1'h1);
        get(16'h5a00 | {12'h0, s, i}, st, low);
        if (st == 0) cmp("strobe_len", 16'(STROBE_CYC), 16'(low));
        else cmp("stretch", 16'h1, {15'h0, low > STROBE_CYC + 2});
    endtask
    task automatic t_dma(input logic s);
        put(1'h1, s, 1'h0, 1'h1, 3'h0, 16'h0f0f);
        take(20, 1'h0);
        pri_dma_request_i = !s;
        sec_dma_request_i = s;
        take(40, 1'h1);
        cmp("ack_n", {14'h0, !s, s},
            {14'h0, sec_dma_ack_n_o, pri_dma_ack_n_o});
        tick(14);
        cmp("ack_idle", 16'h3,
            {14'h0, sec_dma_ack_n_o, pri_dma_ack_n_o});
        {pri_dma_request_i, sec_dma_request_i} = 2'h0;
    endtask
    task automatic t_status;
        {pri_drive_irq_i, sec_drive_irq_i, sec_dma_request_i} = 3'h5;
        tick(3);
        cmp("status", 16'h9, {12'h0, pri_irq_o, sec_irq_o,
            pri_dma_pending_o, sec_dma_pending_o});
        {pri_drive_irq_i, sec_drive_irq_i, sec_dma_request_i} = 3'h2;
        pri_dma_request_i = 1'h1;
        tick(3);
        cmp("status", 16'h6, {12'h0, pri_irq_o, sec_irq_o,
            pri_dma_pending_o, sec_dma_pending_o});
        {sec_drive_irq_i, pri_dma_request_i} = 2'h0;
    endtask
    task automatic t_buf;
        int low;
        rd_ready_i = 1'h0;
        drive_channel_ready_i = 1'h1;
        put(1'h0, 1'h0, 1'h0, 1'h0, 3'h1, 16'h0);
        take(40, 1'h1);
        tick(16);
        put(1'h0, 1'h1, 1'h1, 1'h0, 3'h2, 16'h0);
        take(40, 1'h1);
        tick(16);
        put(1'h0, 1'h0, 1'h1, 1'h0, 3'h7, 16'h0);
        take(30, 1'h0);
        cmp("rd_head", 16'h5a01, rd_data_o);
        rd_ready_i = 1'h1;
        tick(1);
        cmp("rd_next", 16'h5a0a, rd_data_o);
        take(40, 1'h1);
        get(16'h5a07, 0, low);
    endtask
    // ====================
    // Main sequence and watchdog
    initial
    begin
        {req_valid_i, req_write_i, req_sec_i, req_aux_i, req_dma_i} = '0;
        {req_index_i, req_wdata_i, rd_ready_i} = {19'h0, 1'h1};
        {pri_dma_request_i, sec_dma_request_i} = 2'h0;
        {pri_drive_irq_i, sec_drive_irq_i} = 2'h0;
        drive_channel_ready_i = 1'h1;
        t_reset(1'h1);
        t_wr(1'h0, 1'h0, 3'h0, 16'h1234);
        t_wr(1'h1, 1'h1, 3'h6, 16'hfedc);
        t_wr(1'h0, 1'h1, 3'h7, 16'h8001);
        t_rd(1'h0, 1'h0, 3'h5, 0);
        t_rd(1'h1, 1'h0, 3'h2, 16);
        t_rd(1'h0, 1'h1, 3'h6, 16);
        t_rd(1'h1, 1'h1, 3'h1, 0);
        t_dma(1'h0);
        t_dma(1'h1);
        t_status;
        t_buf;
        t_reset(1'h0);
        t_wr(1'h1, 1'h0, 3'h4, 16'h5555);
        tally_and_finish;
    end
    initial
    begin
        #(25 * 6000);
        err_count++;
        tally_and_finish;
    end
endmodule // ide_dual_port_interface_tb_top
bind ide_dual_port_interface ide_dual_port_interface_checker chk_u (.*);
`default_nettype wire

// ---- verilog/ide_dual_port_interface.sv ----
// Dual-port drive interface: register cycles, DMA handshakes, strap
`timescale 1ns/100ps
`default_nettype none
module ide_dual_port_interface
    import ide_port_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // Host request
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire logic              req_write_i,
    input  wire logic              req_sec_i,
    input  wire logic              req_aux_i,
    input  wire logic [ADDR_W-1:0] req_index_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    input  wire logic              req_dma_i,
    // Host read data
    output logic                   rd_valid_o,
    input  wire logic              rd_ready_i,
    output logic [DATA_W-1:0]      rd_data_o,
    // Status toward host
    output logic                   native_mode_o,
    output logic                   pri_irq_o,
    output logic                   sec_irq_o,
    output logic                   pri_dma_pending_o,
    output logic                   sec_dma_pending_o,
    // Drive chip selects and strobes
    output logic                   cmd_block_select_n_o,
    input  wire logic              aux_block_select_n_i,
    output logic                   aux_block_select_n_o,
    output logic                   aux_block_select_n_oe_o,
    output logic                   pri_write_strobe_n_o,
    output logic                   pri_read_strobe_n_o,
    output logic                   sec_write_strobe_n_o,
    output logic                   sec_read_strobe_n_o,
    // Drive address and data
    output logic [ADDR_W-1:0]      drive_reg_index_o,
    input  wire logic [DATA_W-1:0] drive_word_bus_i,
    output logic [DATA_W-1:0]      drive_word_bus_o,
    output logic                   drive_word_bus_oe_o,
    // Drive handshakes
    input  wire logic              pri_dma_request_i,
    output logic                   pri_dma_ack_n_o,
    input  wire logic              sec_dma_request_i,
    output logic                   sec_dma_ack_n_o,
    input  wire logic              drive_channel_ready_i,
    input  wire logic              pri_drive_irq_i,
    input  wire logic              sec_drive_irq_i
);
    // ======================================================================
    // Cycle sequencer state
    cyc_state_t          st_ff, nxt_st;
    logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
    logic                wr_ff, nxt_wr, sec_ff, nxt_sec;
    logic [ADDR_W-1:0]   idx_ff, nxt_idx;
    logic [DATA_W-1:0]   wd_ff, nxt_wd;
    logic                cs0_ff, nxt_cs0, cs1_ff, nxt_cs1, cs1_oe_ff, nxt_cs1_oe;
    logic                piow_ff, nxt_piow, pior_ff, nxt_pior;
    logic                siow_ff, nxt_siow, sior_ff, nxt_sior;
    logic                pdak_ff, nxt_pdak, sdak_ff, nxt_sdak;
    logic                oe_ff, nxt_oe, rdy_ff, nxt_rdy;
    logic                push, dma_ok;
    logic                buf_ready;
    logic                strap_done_ff, nxt_strap_done, nat_ff, nxt_nat;
    logic                pirq_ff, sirq_ff, pdrq_ff, sdrq_ff;

    // Count load value, truncated to the counter width
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction

    // Active-low strobe of one port and direction for the latched access
    function automatic logic strobe_n(input logic wr, sec, want_wr, want_sec);
        strobe_n = ~(wr == want_wr && sec == want_sec);
    endfunction

    // ======================================================================
    // Sequencer next state
    always_comb
    begin
        nxt_st = st_ff; nxt_cnt = cnt_ff;
        nxt_wr = wr_ff; nxt_sec = sec_ff;
        nxt_idx = idx_ff; nxt_wd = wd_ff;
        nxt_cs0 = cs0_ff; nxt_cs1 = cs1_ff; nxt_oe = oe_ff;
        nxt_piow = STROBE_IDLE; nxt_pior = STROBE_IDLE;
        nxt_siow = STROBE_IDLE; nxt_sior = STROBE_IDLE;
        nxt_pdak = pdak_ff; nxt_sdak = sdak_ff;
        nxt_rdy = 1'b0;
        push = 1'b0;
        // A DMA word waits until its drive has asked for it
        dma_ok = !req_dma_i || (req_sec_i ? sdrq_ff : pdrq_ff);
        case (st_ff)
            ST_IDLE:
            begin
                nxt_cs0 = 1'b1; nxt_cs1 = 1'b1; nxt_oe = 1'b0;
                nxt_pdak = 1'b1; nxt_sdak = 1'b1;
                if (req_valid_i && buf_ready && strap_done_ff && dma_ok)
                begin
                    nxt_rdy = 1'b1;
                    nxt_wr = req_write_i; nxt_sec = req_sec_i;
                    nxt_idx = req_index_i; nxt_wd = req_wdata_i;
                    // Register access decode picks one select
                    nxt_cs0 = req_dma_i | req_aux_i;
                    nxt_cs1 = req_dma_i | ~req_aux_i;
                    // Acknowledge the port whose drive asked for it
                    nxt_pdak = ~(req_dma_i && !req_sec_i);
                    nxt_sdak = ~(req_dma_i && req_sec_i);
                    nxt_oe  = req_write_i;
                    nxt_cnt = cyc(SETUP_CYC);
                    nxt_st  = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_cnt = cyc(STROBE_CYC);
                    nxt_st  = ST_STROBE;
                    // Strobe falls with the state change: full count low
                    nxt_piow = strobe_n(wr_ff, sec_ff, 1'b1, 1'b0);
                    nxt_pior = strobe_n(wr_ff, sec_ff, 1'b0, 1'b0);
                    nxt_siow = strobe_n(wr_ff, sec_ff, 1'b1, 1'b1);
                    nxt_sior = strobe_n(wr_ff, sec_ff, 1'b0, 1'b1);
                end
                else
                    nxt_cnt = cnt_ff - 1'b1;
            end
            ST_STROBE:
            begin
                // Exactly one strobe, under a select or, for DMA, under the port's acknowledge
                nxt_piow = strobe_n(wr_ff, sec_ff, 1'b1, 1'b0);
                nxt_pior = strobe_n(wr_ff, sec_ff, 1'b0, 1'b0);
                nxt_siow = strobe_n(wr_ff, sec_ff, 1'b1, 1'b1);
                nxt_sior = strobe_n(wr_ff, sec_ff, 1'b0, 1'b1);
                if (cnt_ff != '0)
                    nxt_cnt = cnt_ff - 1'b1;
                else if (drive_channel_ready_i)
                begin
                    // Strobe rises next edge; data held through it
                    nxt_piow = STROBE_IDLE; nxt_pior = STROBE_IDLE;
                    nxt_siow = STROBE_IDLE; nxt_sior = STROBE_IDLE;
                    push = !wr_ff;
                    nxt_cnt = cyc(RECOVER_CYC);
                    nxt_st  = ST_HOLD;
                end
            end
            ST_HOLD:
                nxt_st = ST_RECOVER;
            ST_RECOVER:
            begin
                nxt_oe = 1'b0;
                nxt_cs0 = 1'b1; nxt_cs1 = 1'b1;
                nxt_pdak = 1'b1; nxt_sdak = 1'b1;
                if (cnt_ff == '0)
                    nxt_st = ST_IDLE;
                else
                    nxt_cnt = cnt_ff - 1'b1;
            end
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    // Strap capture and pin select ownership
    always_comb
    begin
        nxt_strap_done = 1'b1;
        nxt_nat = nat_ff;
        nxt_cs1_oe = strap_done_ff;
    end

    // ======================================================================
    // Registers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st_ff <= ST_IDLE; cnt_ff <= '0;
            wr_ff <= 1'b0; sec_ff <= 1'b0;
            idx_ff <= '0; wd_ff <= '0;
            cs0_ff <= 1'b1; cs1_ff <= 1'b1; cs1_oe_ff <= 1'b0;
            piow_ff <= STROBE_IDLE; pior_ff <= STROBE_IDLE;
            siow_ff <= STROBE_IDLE; sior_ff <= STROBE_IDLE;
            pdak_ff <= 1'b1; sdak_ff <= 1'b1;
            oe_ff <= 1'b0; rdy_ff <= 1'b0;
            strap_done_ff <= 1'b0;
            pirq_ff <= 1'b0; sirq_ff <= 1'b0;
            pdrq_ff <= 1'b0; sdrq_ff <= 1'b0;
            // Strap read while reset keeps the select pin released
            nat_ff <= aux_block_select_n_i;
        end
        else
        begin
            st_ff <= nxt_st; cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr; sec_ff <= nxt_sec;
            idx_ff <= nxt_idx; wd_ff <= nxt_wd;
            cs0_ff <= nxt_cs0; cs1_ff <= nxt_cs1; cs1_oe_ff <= nxt_cs1_oe;
            piow_ff <= nxt_piow; pior_ff <= nxt_pior;
            siow_ff <= nxt_siow; sior_ff <= nxt_sior;
            pdak_ff <= nxt_pdak; sdak_ff <= nxt_sdak;
            oe_ff <= nxt_oe; rdy_ff <= nxt_rdy;
            strap_done_ff <= nxt_strap_done; nat_ff <= nxt_nat;
            pirq_ff <= pri_drive_irq_i;
            sirq_ff <= sec_drive_irq_i;
            pdrq_ff <= pri_dma_request_i;
            sdrq_ff <= sec_dma_request_i;
        end
    end

    // Read words pass through a two-entry buffer
    read_skid_buf u_rbuf (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (buf_ready),
        .in_data_i   (drive_word_bus_i),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

    // Pin drivers
    assign req_ready_o             = rdy_ff;
    assign native_mode_o           = nat_ff;
    assign pri_irq_o               = pirq_ff;
    assign sec_irq_o               = sirq_ff;
    assign pri_dma_pending_o       = pdrq_ff;
    assign sec_dma_pending_o       = sdrq_ff;
    assign cmd_block_select_n_o    = cs0_ff;
    assign aux_block_select_n_o    = cs1_ff;
    assign aux_block_select_n_oe_o = cs1_oe_ff;
    assign pri_write_strobe_n_o    = piow_ff;
    assign pri_read_strobe_n_o     = pior_ff;
    assign sec_write_strobe_n_o    = siow_ff;
    assign sec_read_strobe_n_o     = sior_ff;
    assign drive_reg_index_o       = idx_ff;
    assign drive_word_bus_o        = wd_ff;
    assign drive_word_bus_oe_o     = oe_ff;
    assign pri_dma_ack_n_o         = pdak_ff;
    assign sec_dma_ack_n_o         = sdak_ff;
endmodule // ide_dual_port_interface
`default_nettype wire

// ---- verilog/ide_port_pkg.sv ----
// Constants shared by the dual-port drive interface
// ==========================================================================
package ide_port_pkg;
    // Widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    // Timing in ns, converted to 40 MHz cycles
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETUP_NS      = 70;
    localparam int STROBE_NS     = 165;
    localparam int RECOVER_NS    = 30;
    localparam int SETUP_CYC   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    // Buffer depth
    localparam int BUF_DEPTH = 2;
    // Reset values
    localparam logic STROBE_IDLE = 1'b1;
    // Cycle sequencer states
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_SETUP   = 5'b00010,
        ST_STROBE  = 5'b00100,
        ST_RECOVER = 5'b01000,
        ST_HOLD    = 5'b10000
    } cyc_state_t;
endpackage : ide_port_pkg

// ---- verilog/read_skid_buf.sv ----
// Two-entry buffer for words read from the drives
`timescale 1ns/100ps
`default_nettype none
module read_skid_buf
    import ide_port_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // Fill side
    input  wire logic              in_valid_i,
    output logic                   in_ready_o,
    input  wire logic [DATA_W-1:0] in_data_i,
    // Drain side
    output logic                   out_valid_o,
    input  wire logic              out_ready_i,
    output logic [DATA_W-1:0]      out_data_o
);
    // ======================================================================
    // Storage: slot 0 feeds the output, slot 1 catches a word in a stall
    logic [DATA_W-1:0] slot_ff [BUF_DEPTH];
    logic [DATA_W-1:0] nxt_slot [BUF_DEPTH];
    logic              head_ff, nxt_head, skid_ff, nxt_skid;
    logic              push, pop;

    // Next-state computation
    always_comb
    begin
        push     = in_valid_i && !skid_ff;
        pop      = out_ready_i && head_ff;
        nxt_slot = slot_ff;
        nxt_head = head_ff;
        nxt_skid = skid_ff;
        if (pop || !head_ff)
        begin
            // Output slot frees up: refill from the skid slot first
            if (skid_ff)
            begin
                nxt_slot[0] = slot_ff[1];
                nxt_head    = 1'b1;
                nxt_skid    = 1'b0;
            end
            else
            begin
                nxt_head = push;
                if (push)
                    nxt_slot[0] = in_data_i;
            end
        end
        else if (push)
        begin
            nxt_slot[1] = in_data_i;
            nxt_skid    = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            head_ff <= 1'b0;
            skid_ff <= 1'b0;
        end
        else
        begin
            head_ff <= nxt_head;
            skid_ff <= nxt_skid;
        end
        slot_ff <= nxt_slot;
    end

    // Outputs come straight from registers: data from slot 0, flags from head and skid
    assign in_ready_o  = !skid_ff;
    assign out_valid_o = head_ff;
    assign out_data_o  = slot_ff[0];
endmodule // read_skid_buf
`default_nettype wire
